// >>> core/tiom_pkg.sv
/*
  constants, field layouts, reset values and types of the trigger
  input conditioning and output formatting block.
  assumes one 10 MHz system clock and an APB register bus.
*/
// Notes on behaviour
// - adc top bit inverted unless flip off
// - each input captured on selected clock edge
// - separate whole cycle delays for data, bit
// - crossing bit synchronised on its chosen edge
// - crossing bit becomes one cycle pulse
// - lookup table reduces channel value to 8 bits
// - word: data low, flag bit 8, parity top
// - data, flag and parity carry odd parity
// - zero content gives parity only word
// - two channels share output over two cycles
// - first cycle flag names channel, first wins
// - second flag marks empty half, zero data sets it
// - pair starts when either channel non zero
// - four results summed, 10 bits to 9
// - default mode drops top bit, clips 511
// - alternative mode drops lowest sum bit
// - saturated input forces 511 when truncating
// - third mode: lsb on parity, upper nine out
package tiom_pkg;

  localparam int CH_N      = 4;
  localparam int ADC_W     = 10;
  localparam int LUT_W     = 8;
  localparam int LUT_DEPTH = 1024;
  localparam int DLY_W     = 4;
  localparam int DLY_DEPTH = 16;
  localparam int WORD_W    = 10;
  localparam int SUM_W     = 10;
  localparam int JET_W     = 9;
  localparam int ADDR_W    = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INPUT_CTRL  = 16'h0000;
  localparam logic [ADDR_W-1:0] OFS_INPUT_DELAY = 16'h000C;
  localparam logic [ADDR_W-1:0] OFS_JET_MODE    = 16'h0020;
  localparam logic [ADDR_W-1:0] OFS_JET_STATUS  = 16'h0024;
  localparam logic [ADDR_W-1:0] OFS_LUT_BASE    = 16'h1000;

  // field positions
  localparam int CTRL_BIT_EDGE_POS  = 0;
  localparam int CTRL_DATA_EDGE_POS = 1;
  localparam int CTRL_BYPASS_POS    = 3;
  localparam int CTRL_FLIP_OFF_POS  = 4;
  localparam int DLY_BIT_LSB        = 0;
  localparam int DLY_DATA_LSB       = 4;

  // values after reset
  localparam logic             RST_EDGE_SEL = 1'b0;
  localparam logic             RST_BYPASS   = 1'b1;
  localparam logic             RST_FLIP_OFF = 1'b0;
  localparam logic [DLY_W-1:0] RST_DELAY    = 4'h0;
  localparam logic [1:0]       RST_JET_MODE = 2'h0;

  // jet summing modes
  localparam logic [1:0] JET_CLIP_TOP = 2'h0;
  localparam logic [1:0] JET_DROP_LSB = 2'h1;
  localparam logic [1:0] JET_FULL     = 2'h2;

  localparam logic [WORD_W-1:0] ZERO_WORD = 10'h200;
  localparam logic [LUT_W-1:0]  SAT_IN    = 8'hFF;
  localparam logic [JET_W-1:0]  JET_MAX   = 9'h1FF;

  typedef enum logic {MUX_FIRST, MUX_SECOND} tiom_mux_e;

endpackage

// >>> core/tiom_top.sv
/*
  input conditioning, pair multiplexing with odd parity, and four
  channel summing for the trigger outputs; settings and lookup table
  over APB.
  assumes adc data and crossing bits come from outside the clock
  domain and the APB master runs on REF_CLK.
*/
`timescale 1ns/1ps
module tiom_top
  import tiom_pkg::*;
(
  // clock and reset
  input  wire logic                                 REF_CLK,
  input  wire logic                                 RESET,
  // adc samples and external crossing bits
  input  wire logic [tiom_pkg::CH_N-1:0][tiom_pkg::ADC_W-1:0] ADC_DATA,
  input  wire logic [tiom_pkg::CH_N-1:0]            EXT_CROSSING_BIT,
  // cluster processor outputs, pair 0/1 and pair 2/3
  output logic      [tiom_pkg::WORD_W-1:0]          CP_WORD_A,
  output logic      [tiom_pkg::WORD_W-1:0]          CP_WORD_B,
  // jet processor output
  output logic      [tiom_pkg::JET_W-1:0]           JET_SUM,
  output logic                                      JET_PARITY,
  // apb slave
  input  wire logic                                 PSEL,
  input  wire logic                                 PENABLE,
  input  wire logic                                 PWRITE,
  input  wire logic [tiom_pkg::ADDR_W-1:0]          PADDR,
  input  wire logic [31:0]                          PWDATA,
  output logic      [31:0]                          PRDATA,
  output logic                                      PREADY,
  output logic                                      PSLVERR
);
  import tiom_pkg::*;

  // odd parity word from flag and data
  function automatic logic [WORD_W-1:0] make_word(input logic flag, input logic [LUT_W-1:0] d);
    make_word = {~^{flag, d}, flag, d};
  endfunction

  function automatic logic lut_hit(input logic [ADDR_W-1:0] a);
    lut_hit = (a >= OFS_LUT_BASE) && (a < OFS_LUT_BASE + ADDR_W'(4 * LUT_DEPTH));
  endfunction

  // settings
  logic             ext_crossing_bit_fall_edge_sel_q;
  logic             adc_sample_fall_edge_sel_q;
  logic             lut_bypass_q;
  logic             adc_top_bit_flip_off_q;
  logic [DLY_W-1:0] ext_crossing_bit_cycle_delay_q;
  logic [DLY_W-1:0] adc_sample_cycle_delay_q;
  logic [1:0]       jet_mode_q;
  logic [LUT_W-1:0] energy_lookup_table [LUT_DEPTH];

  // apb
  logic             wr_en;
  logic [31:0]      rd_val;
  logic             rd_ok;

  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      ext_crossing_bit_fall_edge_sel_q <= RST_EDGE_SEL;
      adc_sample_fall_edge_sel_q       <= RST_EDGE_SEL;
      lut_bypass_q                     <= RST_BYPASS;
      adc_top_bit_flip_off_q           <= RST_FLIP_OFF;
      ext_crossing_bit_cycle_delay_q   <= RST_DELAY;
      adc_sample_cycle_delay_q         <= RST_DELAY;
      jet_mode_q                       <= RST_JET_MODE;
    end
    else if (wr_en)
    begin
      if (PADDR == OFS_INPUT_CTRL)
      begin
        ext_crossing_bit_fall_edge_sel_q <= PWDATA[CTRL_BIT_EDGE_POS];
        adc_sample_fall_edge_sel_q       <= PWDATA[CTRL_DATA_EDGE_POS];
        lut_bypass_q                     <= PWDATA[CTRL_BYPASS_POS];
        adc_top_bit_flip_off_q           <= PWDATA[CTRL_FLIP_OFF_POS];
      end
      if (PADDR == OFS_INPUT_DELAY)
      begin
        ext_crossing_bit_cycle_delay_q <= PWDATA[DLY_BIT_LSB +: DLY_W];
        adc_sample_cycle_delay_q       <= PWDATA[DLY_DATA_LSB +: DLY_W];
      end
      if (PADDR == OFS_JET_MODE)
        jet_mode_q <= PWDATA[1:0];
    end
  end

  // table contents, not reset
  always_ff @(posedge REF_CLK)
  begin
    if (wr_en && lut_hit(PADDR))
      energy_lookup_table[PADDR[11:2]] <= PWDATA[LUT_W-1:0];
  end

  always_comb
  begin
    rd_ok  = 1'b1;
    rd_val = '0;
    if (PADDR == OFS_INPUT_CTRL)
      rd_val = 32'({adc_top_bit_flip_off_q, lut_bypass_q, 1'b0,
                    adc_sample_fall_edge_sel_q, ext_crossing_bit_fall_edge_sel_q});
    else if (PADDR == OFS_INPUT_DELAY)
      rd_val = 32'({adc_sample_cycle_delay_q, ext_crossing_bit_cycle_delay_q});
    else if (PADDR == OFS_JET_MODE)
      rd_val = 32'(jet_mode_q);
    else if (PADDR == OFS_JET_STATUS)
      rd_val = 32'({JET_PARITY, JET_SUM});
    else if (lut_hit(PADDR))
      rd_val = 32'(energy_lookup_table[PADDR[11:2]]);
    else
      rd_ok = 1'b0;
  end

  // no wait cycle: setup loads answer, access completes
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & ~PENABLE;
      PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_val : '0;
      PSLVERR <= PSEL & ~PENABLE & ~rd_ok;
    end
  end

  // two flop capture on each edge
  logic [CH_N-1:0][ADC_W-1:0] adc_rise1_q, adc_rise2_q, adc_fall1_q, adc_fall2_q;
  logic [CH_N-1:0]            bit_rise1_q, bit_rise2_q, bit_fall1_q, bit_fall2_q;

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      adc_rise1_q <= '0;
      adc_rise2_q <= '0;
      bit_rise1_q <= '0;
      bit_rise2_q <= '0;
    end
    else
    begin
      adc_rise1_q <= ADC_DATA;
      adc_rise2_q <= adc_rise1_q;
      bit_rise1_q <= EXT_CROSSING_BIT;
      bit_rise2_q <= bit_rise1_q;
    end
  end

  always_ff @(negedge REF_CLK)
  begin
    if (RESET)
    begin
      adc_fall1_q <= '0;
      adc_fall2_q <= '0;
      bit_fall1_q <= '0;
      bit_fall2_q <= '0;
    end
    else
    begin
      adc_fall1_q <= ADC_DATA;
      adc_fall2_q <= adc_fall1_q;
      bit_fall1_q <= EXT_CROSSING_BIT;
      bit_fall2_q <= bit_fall1_q;
    end
  end

  // delay lines
  logic [CH_N-1:0][ADC_W-1:0] adc_line_q [DLY_DEPTH];
  logic [CH_N-1:0]            bit_line_q [DLY_DEPTH];

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < DLY_DEPTH; i++)
      begin
        adc_line_q[i] <= '0;
        bit_line_q[i] <= '0;
      end
    end
    else
    begin
      adc_line_q[0] <= adc_sample_fall_edge_sel_q ? adc_fall2_q : adc_rise2_q;
      bit_line_q[0] <= ext_crossing_bit_fall_edge_sel_q ? bit_fall2_q : bit_rise2_q;
      for (int i = 1; i < DLY_DEPTH; i++)
      begin
        adc_line_q[i] <= adc_line_q[i-1];
        bit_line_q[i] <= bit_line_q[i-1];
      end
    end
  end

  logic [CH_N-1:0][ADC_W-1:0] adc_late;
  logic [CH_N-1:0][ADC_W-1:0] adc_fix;
  logic [CH_N-1:0]            bit_late;
  logic [CH_N-1:0]            bit_prev_q;
  logic [CH_N-1:0]            bit_pulse_q;
  logic [CH_N-1:0][LUT_W-1:0] energy_q;
  logic [CH_N-1:0][LUT_W-1:0] res_q;

  assign adc_late = adc_line_q[adc_sample_cycle_delay_q];
  assign bit_late = bit_line_q[ext_crossing_bit_cycle_delay_q];

  always_comb
  begin
    for (int c = 0; c < CH_N; c++)
      adc_fix[c] = {adc_late[c][ADC_W-1] ^ ~adc_top_bit_flip_off_q,
                    adc_late[c][ADC_W-2:0]};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      bit_prev_q  <= '0;
      bit_pulse_q <= '0;
      energy_q    <= '0;
      res_q       <= '0;
    end
    else
    begin
      bit_prev_q  <= bit_late;
      bit_pulse_q <= bit_late & ~bit_prev_q;
      for (int c = 0; c < CH_N; c++)
      begin
        energy_q[c] <= lut_bypass_q ? adc_fix[c][ADC_W-1 -: LUT_W]
                                    : energy_lookup_table[adc_fix[c]];
        res_q[c]    <= bit_pulse_q[c] ? energy_q[c] : '0;
      end
    end
  end

  // pair multiplexing
  tiom_mux_e        mux_st_q [2];
  logic [LUT_W-1:0] pend_q   [2];
  logic [WORD_W-1:0] cp_q    [2];

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      for (int p = 0; p < 2; p++)
      begin
        mux_st_q[p] <= MUX_FIRST;
        pend_q[p]   <= '0;
        cp_q[p]     <= ZERO_WORD;
      end
    end
    else
    begin
      for (int p = 0; p < 2; p++)
      begin
        unique case (mux_st_q[p])
          MUX_FIRST:
          begin
            if (res_q[2*p] != '0)
            begin
              cp_q[p]     <= make_word(1'b0, res_q[2*p]);
              pend_q[p]   <= res_q[2*p+1];
              mux_st_q[p] <= MUX_SECOND;
            end
            else if (res_q[2*p+1] != '0)
            begin
              cp_q[p]     <= make_word(1'b1, res_q[2*p+1]);
              pend_q[p]   <= '0;
              mux_st_q[p] <= MUX_SECOND;
            end
            else
              cp_q[p] <= ZERO_WORD;
          end
          MUX_SECOND:
          begin
            if (pend_q[p] != '0)
              cp_q[p] <= make_word(1'b0, pend_q[p]);
            else
              cp_q[p] <= make_word(1'b1, '0);
            mux_st_q[p] <= MUX_FIRST;
          end
        endcase
      end
    end
  end

  assign CP_WORD_A = cp_q[0];
  assign CP_WORD_B = cp_q[1];

  // jet sum
  logic [SUM_W-1:0] sum;
  logic             any_sat;

  always_comb
  begin
    sum     = '0;
    any_sat = 1'b0;
    for (int c = 0; c < CH_N; c++)
    begin
      sum     = sum + SUM_W'(res_q[c]);
      any_sat = any_sat | (res_q[c] == SAT_IN);
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      JET_SUM    <= '0;
      JET_PARITY <= 1'b1;
    end
    else if (jet_mode_q == JET_FULL)
    begin
      JET_SUM    <= sum[SUM_W-1:1];
      JET_PARITY <= sum[0];
    end
    else if (any_sat || (jet_mode_q != JET_DROP_LSB && sum[SUM_W-1]))
    begin
      JET_SUM    <= JET_MAX;
      JET_PARITY <= ~^JET_MAX;
    end
    else if (jet_mode_q == JET_DROP_LSB)
    begin
      JET_SUM    <= sum[SUM_W-1:1];
      JET_PARITY <= ~^sum[SUM_W-1:1];
    end
    else
    begin
      JET_SUM    <= sum[JET_W-1:0];
      JET_PARITY <= ~^sum[JET_W-1:0];
    end
  end

  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence pair_start_s;
    mux_st_q[0] == MUX_FIRST && res_q[0] != '0;
  endsequence

  sequence pair_sent_s;
    CP_WORD_A[LUT_W] == 1'b0 && mux_st_q[0] == MUX_SECOND;
  endsequence

  flip_on_a: assert property (!adc_top_bit_flip_off_q |->
    adc_fix[0][ADC_W-1] != adc_late[0][ADC_W-1])
    else $error("adc top bit not inverted");

  pulse_one_a: assert property (bit_pulse_q[0] |=> !bit_pulse_q[0])
    else $error("crossing pulse longer than one cycle");

  odd_parity_a: assert property (^CP_WORD_A == 1'b1 && ^CP_WORD_B == 1'b1)
    else $error("cluster word parity not odd");

  first_chan_a: assert property (pair_start_s |=> pair_sent_s ##1
    (mux_st_q[0] == MUX_FIRST))
    else $error("first channel not sent first");

  second_zero_a: assert property (mux_st_q[0] == MUX_SECOND && pend_q[0] == '0
    |=> CP_WORD_A[LUT_W] && CP_WORD_A[LUT_W-1:0] == '0)
    else $error("zero second half lacks flag");

  idle_zero_a: assert property (mux_st_q[0] == MUX_FIRST && res_q[0] == '0 &&
    res_q[1] == '0 |=> CP_WORD_A == ZERO_WORD)
    else $error("idle word not zero word");

  jet_sat_a: assert property (jet_mode_q != JET_FULL && any_sat
    |=> JET_SUM == JET_MAX)
    else $error("saturation not forced to maximum");

  jet_clip_a: assert property (jet_mode_q == JET_CLIP_TOP && sum[SUM_W-1]
    |=> JET_SUM == JET_MAX)
    else $error("overflow not clipped");

  jet_full_a: assert property (jet_mode_q == JET_FULL
    |=> {JET_SUM, JET_PARITY} == $past(sum))
    else $error("full mode sum split wrong");

endmodule // tiom_top

// >>> tb/tiom_adc_src.sv
/*
  adc and crossing bit source facing the trigger block inputs.
  assumes one command pulse per burst; holds data one cycle early,
  then data with crossing bits for three cycles, then a wandering pattern.
*/
`timescale 1ns/1ps
module tiom_adc_src
  import tiom_pkg::*;
(
  // clock and command
  input  wire logic                                           clk,
  input  wire logic                                           go,
  input  wire logic [tiom_pkg::CH_N-1:0]                      mask,
  input  wire logic [tiom_pkg::CH_N-1:0][tiom_pkg::ADC_W-1:0] pre,
  input  wire logic [tiom_pkg::CH_N-1:0][tiom_pkg::ADC_W-1:0] val,
  // pins towards the block
  output logic      [tiom_pkg::CH_N-1:0][tiom_pkg::ADC_W-1:0] adc_data,
  output logic      [tiom_pkg::CH_N-1:0]                      crossing_bit
);
  logic [2:0]       step_q;
  logic [ADC_W-1:0] walk_q;

  initial
  begin
    step_q = 3'h0;
    walk_q = 10'h155;
    adc_data = '0;
    crossing_bit = '0;
  end

  // data outside a burst never holds still
  always @(posedge clk)
  begin
    walk_q <= walk_q + 10'h0D3;
    if (go)
    begin
      adc_data <= pre;
      crossing_bit <= '0;
      step_q <= 3'h1;
    end
    else if (step_q != 3'h0 && step_q < 3'h4)
    begin
      adc_data <= val;
      crossing_bit <= mask;
      step_q <= step_q + 3'h1;
    end
    else
    begin
      adc_data <= {4{walk_q}};
      crossing_bit <= '0;
      step_q <= 3'h0;
    end
  end
endmodule // tiom_adc_src

// >>> tb/tiom_top_tb.sv
/*
  self-checking bench of the trigger block: apb settings, bursts from the
  adc source, expected words queued and matched as outputs appear.
  assumes lut bypass stays on until the last scenario and a 10 MHz clock.
*/
`timescale 1ns/1ps
module tiom_top_tb;
  import tiom_pkg::*;
  typedef struct {logic [WORD_W-1:0] a; logic [WORD_W-1:0] b; logic [JET_W-1:0] j; logic p;} tiom_note_s;

  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [CH_N-1:0][ADC_W-1:0] ADC_DATA, tb_pre, tb_val;
  logic [CH_N-1:0] EXT_CROSSING_BIT, tb_mask;
  logic [WORD_W-1:0] CP_WORD_A, CP_WORD_B;
  logic [JET_W-1:0] JET_SUM;
  logic JET_PARITY, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, tb_go;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [7:0] cfg_ctrl [4] = '{8'h08, 8'h18, 8'h0B, 8'h08};
  logic [7:0] cfg_dly [4] = '{8'h00, 8'h00, 8'h22, 8'h10};
  tiom_note_s notes[$];
  tiom_note_s got;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 77;
  int cyc = 0;
  logic flip_off, samp_pre, lut_on = 1'b0;
  logic [1:0] mode;

  always #50 REF_CLK = ~REF_CLK;

  tiom_top tiom_top_inst (.REF_CLK(REF_CLK), .RESET(RESET), .ADC_DATA(ADC_DATA),
    .EXT_CROSSING_BIT(EXT_CROSSING_BIT), .CP_WORD_A(CP_WORD_A), .CP_WORD_B(CP_WORD_B),
    .JET_SUM(JET_SUM), .JET_PARITY(JET_PARITY), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  tiom_adc_src tiom_adc_src_inst (.clk(REF_CLK), .go(tb_go), .mask(tb_mask), .pre(tb_pre),
    .val(tb_val), .adc_data(ADC_DATA), .crossing_bit(EXT_CROSSING_BIT));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    chk({31'h0, PREADY}, 32'h1);
    if (!w)
      chk(PRDATA, er);
    chk({31'h0, PSLVERR}, {31'h0, ee});
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  function automatic logic [9:0] mk(input logic f, input logic [7:0] d);
    return {~^{f, d}, f, d};
  endfunction

  function automatic logic [9:0] pair(input logic [7:0] c0, input logic [7:0] c1, input logic s);
    if (c0 == 8'h00 && c1 == 8'h00)
      return ZERO_WORD;
    if (!s)
      return (c0 != 8'h00) ? mk(1'b0, c0) : mk(1'b1, c1);
    return (c1 != 8'h00 && c0 != 8'h00) ? mk(1'b0, c1) : mk(1'b1, 8'h00);
  endfunction

  function automatic logic [39:0] rnd40();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[39:0];
  endfunction

  task automatic fire(input logic [3:0] m, input logic [39:0] pv, input logic [39:0] vv);
    logic [3:0][7:0] r;
    logic [3:0][9:0] x;
    logic [9:0] s;
    logic sat;
    tiom_note_s n1, n2;
    x = samp_pre ? pv : vv;
    s = 10'h000;
    sat = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r[i] = m[i] ? (lut_on ? 8'h5A : {x[i][9] ^ ~flip_off, x[i][8:2]}) : 8'h00;
      s = s + {2'b00, r[i]};
      sat = sat | (r[i] == SAT_IN);
    end
    n1.a = pair(r[0], r[1], 1'b0);
    n1.b = pair(r[2], r[3], 1'b0);
    n2.a = pair(r[0], r[1], 1'b1);
    n2.b = pair(r[2], r[3], 1'b1);
    if (mode == JET_FULL)
      n1.j = s[9:1];
    else if (mode == JET_DROP_LSB)
      n1.j = sat ? JET_MAX : s[9:1];
    else
      n1.j = (sat || s[9]) ? JET_MAX : s[8:0];
    n1.p = (mode == JET_FULL) ? s[0] : ~^n1.j;
    n2.j = 9'h000;
    n2.p = (mode != JET_FULL);
    if (n1.a !== ZERO_WORD || n1.b !== ZERO_WORD || n1.j !== 9'h000)
      notes.push_back(n1);
    if (n2.a !== ZERO_WORD || n2.b !== ZERO_WORD)
      notes.push_back(n2);
    tb_go <= 1'b1;
    tb_mask <= m;
    tb_pre <= pv;
    tb_val <= vv;
    @(posedge REF_CLK);
    tb_go <= 1'b0;
    repeat (20) @(posedge REF_CLK);
  endtask

  // results noticed by their non-zero content
  always @(negedge REF_CLK)
  begin
    if (!RESET && (CP_WORD_A !== ZERO_WORD || CP_WORD_B !== ZERO_WORD || JET_SUM !== 9'h000))
    begin
      if (notes.size() == 0)
      begin
        fail_count++;
        $display("[ERR] %0t unexpected output", $time);
      end
      else
      begin
        got = notes.pop_front();
        chk(CP_WORD_A, got.a);
        chk(CP_WORD_B, got.b);
        chk(JET_SUM, got.j);
        chk(JET_PARITY, got.p);
      end
    end
  end

  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      $display("[ERR] %0t run timed out", $time);
      give_verdict;
    end
  end

  initial
  begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, tb_go, tb_mask, tb_pre, tb_val} = '0;
    repeat (4) @(posedge REF_CLK);
    RESET <= 1'b0;
    @(posedge REF_CLK);
    chk(CP_WORD_A, ZERO_WORD);
    apb(1'b0, OFS_INPUT_CTRL, 32'h0, 32'h8, 1'b0);
    apb(1'b0, OFS_INPUT_DELAY, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_JET_STATUS, 32'h0, 32'h200, 1'b0);
    apb(1'b0, 16'h0100, 32'h0, 32'h0, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      if (c > 0)
      begin
        apb(1'b1, OFS_INPUT_CTRL, {24'h0, cfg_ctrl[c]}, 32'h0, 1'b0);
        apb(1'b1, OFS_INPUT_DELAY, {24'h0, cfg_dly[c]}, 32'h0, 1'b0);
        apb(1'b1, OFS_JET_MODE, c, 32'h0, 1'b0);
      end
      flip_off = cfg_ctrl[c][4];
      samp_pre = cfg_dly[c][7:4] > cfg_dly[c][3:0];
      mode = c[1:0];
      fire(4'h1, {4{flip_off ? 10'h3FF : 10'h1FF}}, {4{flip_off ? 10'h3FF : 10'h1FF}});
      repeat (6) fire(rnd40() >> 36, rnd40(), rnd40());
      $display("config %0d done", c);
    end
    // table entry for adc 0x155 with inversion on: index 0x355
    apb(1'b1, OFS_LUT_BASE + 16'h0D54, 32'h5A, 32'h0, 1'b0);
    apb(1'b0, OFS_LUT_BASE + 16'h0D54, 32'h0, 32'h5A, 1'b0);
    apb(1'b1, OFS_INPUT_CTRL, 32'h0, 32'h0, 1'b0);
    apb(1'b1, OFS_INPUT_DELAY, 32'h0, 32'h0, 1'b0);
    apb(1'b1, OFS_JET_MODE, 32'h0, 32'h0, 1'b0);
    apb(1'b0, OFS_INPUT_CTRL, 32'h0, 32'h0, 1'b0);
    flip_off = 1'b0;
    samp_pre = 1'b0;
    mode = JET_CLIP_TOP;
    lut_on = 1'b1;
    fire(4'h1, {4{10'h155}}, {4{10'h155}});
    fire(4'h2, {4{10'h155}}, {4{10'h155}});
    $display("lookup table test done");
    chk(notes.size(), 32'h0);
    give_verdict;
  end
endmodule // tiom_top_tb
